// ==== include/oss_pkg.sv ====
// Constants and types for the oscillator source selector.
// Assumes a single 250 MHz bus clock and a word-aligned AHB-Lite register map.
// How it works
// - Codes 111,110,101,100 pick internal or secondary sources.
// - 011 primary with PLL, 010 primary direct.
// - 001 fast RC with PLL, 000 plain.
// - Erased configuration boots in divide-by-N fast RC.
// - Second oscillator pin function follows its config bit, except in a crystal mode on a primary source.
// - PLL output is input times M over N1*N2.
// - PLL oscillator is input times M over N1.
// - Auxiliary PLL oscillator is input times M over N1.
// - Current source is read-only at bits 14-12.
// - Requested source at bits 10-8, loaded at boot.
// - Lock bits 7, 6 writable; PLL lock 5 read-only.
// - Clock-fail bit 3, enable bit 1, request bit 0.
// - Bits 15, 11, 4, 2 read as zero.
package oss_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PLL  = 8'h04;
    localparam logic [7:0] OFF_AUX  = 8'h08;
    localparam logic [7:0] OFF_STS  = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;

    localparam int CUR_SRC_LSB  = 12;
    localparam int REQ_SRC_LSB  = 8;
    localparam int SRC_LOCK_BIT = 7;
    localparam int PIN_LOCK_BIT = 6;
    localparam int LOCK_BIT     = 5;
    localparam int FAIL_BIT     = 3;
    localparam int LPOSC_BIT    = 1;
    localparam int REQ_BIT      = 0;

    localparam int PRE_LSB   = 0;
    localparam int POST_LSB  = 6;
    localparam int DIV_LSB   = 16;
    localparam int APRE_LSB  = 0;
    localparam int ADIV_LSB  = 8;

    localparam int IRQ_SWITCH = 0;
    localparam int IRQ_FAIL   = 1;

    localparam logic [4:0] PRE_RST  = 5'h00;
    localparam logic [1:0] POST_RST = 2'h0;
    localparam logic [8:0] DIV_RST  = 9'h000;
    localparam logic [2:0] APRE_RST = 3'h0;
    localparam logic [5:0] ADIV_RST = 6'h00;
    localparam logic [1:0] IRQ_RST  = 2'h0;

    localparam int PLL_ADD  = 2;
    localparam int POST_MUL = 2;

    localparam logic [1:0] PM_EXT       = 2'h0;
    localparam logic [1:0] PM_XTAL      = 2'h1;
    localparam logic [1:0] PM_FAST_XTAL = 2'h2;

    typedef enum logic [2:0] {
        SRC_FAST     = 3'b000,
        SRC_FAST_PLL = 3'b001,
        SRC_PRI      = 3'b010,
        SRC_PRI_PLL  = 3'b011,
        SRC_SEC      = 3'b100,
        SRC_SLOW     = 3'b101,
        SRC_FAST_16  = 3'b110,
        SRC_FAST_N   = 3'b111
    } oss_src_type;

    typedef enum logic {
        SW_IDLE = 1'b0,
        SW_WAIT = 1'b1
    } oss_sw_type;
endpackage

// ==== verilog/oss_pll_ratio.sv ====
// Divide ratios of the main and auxiliary PLL from their fields.
// Assumes the fields come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module oss_pll_ratio (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    input  wire logic [4:0] pre,
    input  wire logic [1:0] post,
    input  wire logic [8:0] div,
    input  wire logic [2:0] apre,
    input  wire logic [5:0] adiv,
    output logic      [9:0] m_ff,
    output logic      [5:0] n1_ff,
    output logic      [3:0] n2_ff,
    output logic      [6:0] am_ff,
    output logic      [3:0] an1_ff
);
    import oss_pkg::*;

    logic [9:0] nxt_m;
    logic [5:0] nxt_n1;
    logic [3:0] nxt_n2;
    logic [6:0] nxt_am;
    logic [3:0] nxt_an1;

    always_comb begin
        nxt_m   = 10'(div) + 10'(PLL_ADD);
        nxt_n1  = 6'(pre) + 6'(PLL_ADD);
        nxt_n2  = 4'(POST_MUL) * (4'(post) + 4'h1);
        nxt_am  = 7'(adiv) + 7'(PLL_ADD);
        nxt_an1 = 4'(apre) + 4'(PLL_ADD);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            m_ff   <= 10'h000;
            n1_ff  <= 6'h00;
            n2_ff  <= 4'h0;
            am_ff  <= 7'h00;
            an1_ff <= 4'h0;
        end else if (ce) begin
            m_ff   <= nxt_m;
            n1_ff  <= nxt_n1;
            n2_ff  <= nxt_n2;
            am_ff  <= nxt_am;
            an1_ff <= nxt_an1;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_PLL_OUT: assert property (ce |=> m_ff == $past(div) + 10'h2
        && n2_ff == ($past(post) + 4'h1) * 4'h2)
        else $error("PLL M or N2 wrong");
    AST_PLL_VCO: assert property (ce |=> n1_ff == $past(pre) + 6'h2)
        else $error("PLL N1 wrong");
    AST_AUXILIARY_PLL: assert property (ce |=> am_ff == $past(adiv) + 7'h2
        && an1_ff == $past(apre) + 4'h2)
        else $error("Auxiliary PLL ratio wrong");
endmodule
`default_nettype wire

// ==== verilog/oss_ctrl.sv ====
// Oscillator source selector with its AHB-Lite register slave.
// Assumes oscillator ready, PLL lock and clock-fail inputs come
// asynchronously from analog cells, and configuration straps are static.
`timescale 1ns/1ps
`default_nettype none
module oss_ctrl (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                ce,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata_ff,
    output logic                     hreadyout_ff,
    output logic                     hresp_ff,
    input  wire logic [2:0]          initial_source_config,
    input  wire logic [1:0]          primary_mode_config,
    input  wire logic                osc2_pin_function_cfg,
    input  wire logic                config_erased,
    input  wire logic [7:0]          src_ready_in,
    input  wire logic                pll_lock_in,
    input  wire logic                clock_fail_in,
    output oss_pkg::oss_src_type     cur_source_ff,
    output logic                     pll_enable_ff,
    output logic                     osc2_gpio_ff,
    output logic                     sec_osc_on_ff,
    output logic                     pin_config_lock_ff,
    output logic                     irq_ff,
    output logic      [9:0]          pll_m_ff,
    output logic      [5:0]          pll_n1_ff,
    output logic      [3:0]          pll_n2_ff,
    output logic      [6:0]          aux_m_ff,
    output logic      [3:0]          aux_n1_ff
);
    import oss_pkg::*;

    // Two-stage synchronisers for the asynchronous analog status inputs.
    logic [9:0] sync_in;
    logic [9:0] meta_ff;
    logic [9:0] sync_ff;
    assign sync_in = {clock_fail_in, pll_lock_in, src_ready_in};

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else if (ce) begin
                    meta_ff[gi] <= sync_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    logic [7:0] rdy_s;
    logic       lock_s;
    logic       fail_s;
    assign rdy_s  = sync_ff[7:0];
    assign lock_s = sync_ff[8];
    assign fail_s = sync_ff[9];

    // Bus state.
    logic        pend_ff;
    logic        wr_ff;
    logic [7:0]  addr_ff;
    logic        take;
    logic        nxt_pend;
    logic        nxt_wr;
    logic [7:0]  nxt_addr;
    logic        nxt_hreadyout;
    logic [31:0] nxt_hrdata;
    logic [31:0] rd_word;

    // Control state.
    logic [2:0]  req_src_ff;
    logic        src_lock_ff;
    logic        fail_flag_ff;
    logic        lposc_ff;
    logic        req_ff;
    logic        boot_ff;
    logic        fail_q_ff;
    oss_sw_type  sw_ff;
    logic [4:0]  pre_ff;
    logic [1:0]  post_ff;
    logic [8:0]  div_ff;
    logic [2:0]  apre_ff;
    logic [5:0]  adiv_ff;
    logic [1:0]  sts_ff;
    logic [1:0]  mask_ff;

    logic [2:0]  nxt_req_src;
    oss_src_type nxt_cur_src;
    logic        nxt_src_lock;
    logic        nxt_pin_lock;
    logic        nxt_fail_flag;
    logic        nxt_lposc;
    logic        nxt_req;
    oss_sw_type  nxt_sw;
    logic [4:0]  nxt_pre;
    logic [1:0]  nxt_post;
    logic [8:0]  nxt_div;
    logic [2:0]  nxt_apre;
    logic [5:0]  nxt_adiv;
    logic [1:0]  nxt_sts;
    logic [1:0]  nxt_mask;
    logic        nxt_pll_en;
    logic        nxt_osc2;
    logic        nxt_sec_on;
    logic        nxt_irq;

    oss_src_type boot_src;
    logic        wr_ctrl;
    logic        rd_ctrl;
    logic        fail_rise;
    logic        src_ok;
    logic        crystal;
    logic [1:0]  sts_set;

    assign take    = hsel && htrans[1] && hready;
    assign wr_ctrl = pend_ff && wr_ff && addr_ff == OFF_CTRL;
    assign rd_ctrl = pend_ff && !wr_ff && addr_ff == OFF_CTRL;
    assign fail_rise = fail_s && !fail_q_ff;

    always_comb begin
        boot_src = config_erased ? SRC_FAST_N
                                 : oss_src_type'(initial_source_config);
        // PLL sources also wait for the PLL to report lock.
        src_ok = rdy_s[req_src_ff] && (lock_s ||
                 !(req_src_ff == SRC_PRI_PLL ||
                   req_src_ff == SRC_FAST_PLL));
        // The primary mode only matters on primary sources.
        crystal = (cur_source_ff == SRC_PRI ||
                   cur_source_ff == SRC_PRI_PLL) &&
                  (primary_mode_config == PM_FAST_XTAL ||
                   primary_mode_config == PM_XTAL);
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (addr_ff)
            OFF_CTRL: begin
                rd_word[CUR_SRC_LSB +: 3] = cur_source_ff;
                rd_word[REQ_SRC_LSB +: 3] = req_src_ff;
                rd_word[SRC_LOCK_BIT]     = src_lock_ff;
                rd_word[PIN_LOCK_BIT]     = pin_config_lock_ff;
                rd_word[LOCK_BIT]         = lock_s;
                rd_word[FAIL_BIT]         = fail_flag_ff;
                rd_word[LPOSC_BIT]        = lposc_ff;
                rd_word[REQ_BIT]          = req_ff;
            end
            OFF_PLL: begin
                rd_word[PRE_LSB +: 5]   = pre_ff;
                rd_word[POST_LSB +: 2]  = post_ff;
                rd_word[DIV_LSB +: 9]   = div_ff;
            end
            OFF_AUX: begin
                rd_word[APRE_LSB +: 3]  = apre_ff;
                rd_word[ADIV_LSB +: 6]  = adiv_ff;
            end
            OFF_STS:  rd_word[1:0] = sts_ff;
            OFF_MASK: rd_word[1:0] = mask_ff;
            default:  rd_word = 32'h0000_0000;
        endcase
    end

    // Every transfer gets one wait state so read data can leave a flop.
    always_comb begin
        nxt_pend      = take;
        nxt_wr        = take ? hwrite : wr_ff;
        nxt_addr      = take ? haddr[7:0] : addr_ff;
        nxt_hreadyout = !take;
        nxt_hrdata    = (pend_ff && !wr_ff) ? rd_word : hrdata_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_ff      <= 1'b0;
            wr_ff        <= 1'b0;
            addr_ff      <= 8'h00;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h0000_0000;
            hresp_ff     <= 1'b0;
        end else if (ce) begin
            pend_ff      <= nxt_pend;
            wr_ff        <= nxt_wr;
            addr_ff      <= nxt_addr;
            hreadyout_ff <= nxt_hreadyout;
            hrdata_ff    <= nxt_hrdata;
            hresp_ff     <= 1'b0;
        end
    end

    always_comb begin
        nxt_req_src   = req_src_ff;
        nxt_cur_src   = cur_source_ff;
        nxt_src_lock  = src_lock_ff;
        nxt_pin_lock  = pin_config_lock_ff;
        nxt_fail_flag = fail_flag_ff;
        nxt_lposc     = lposc_ff;
        nxt_req       = req_ff;
        nxt_sw      = sw_ff;
        nxt_pre     = pre_ff;
        nxt_post    = post_ff;
        nxt_div     = div_ff;
        nxt_apre    = apre_ff;
        nxt_adiv    = adiv_ff;
        nxt_mask    = mask_ff;
        nxt_sts     = sts_ff;
        sts_set     = 2'h0;
        if (!boot_ff) begin
            nxt_req_src = boot_src;
            nxt_cur_src = boot_src;
        end else begin
            if (pend_ff && wr_ff) begin
                unique case (addr_ff)
                    OFF_CTRL: begin
                        // A set lock freezes the source choice.
                        if (!src_lock_ff) begin
                            nxt_req_src = hwdata[REQ_SRC_LSB +: 3];
                            nxt_req = req_ff || hwdata[REQ_BIT];
                        end
                        nxt_src_lock = hwdata[SRC_LOCK_BIT];
                        nxt_pin_lock = hwdata[PIN_LOCK_BIT];
                        nxt_lposc    = hwdata[LPOSC_BIT];
                        if (!hwdata[FAIL_BIT]) begin
                            nxt_fail_flag = 1'b0;
                        end
                    end
                    OFF_PLL: begin
                        nxt_pre  = hwdata[PRE_LSB +: 5];
                        nxt_post = hwdata[POST_LSB +: 2];
                        nxt_div  = hwdata[DIV_LSB +: 9];
                    end
                    OFF_AUX: begin
                        nxt_apre = hwdata[APRE_LSB +: 3];
                        nxt_adiv = hwdata[ADIV_LSB +: 6];
                    end
                    OFF_STS:  nxt_sts = sts_ff & ~hwdata[1:0];
                    OFF_MASK: nxt_mask = hwdata[1:0];
                    default: ;
                endcase
            end
            unique case (sw_ff)
                SW_IDLE: if (req_ff) nxt_sw = SW_WAIT;
                SW_WAIT: if (src_ok) begin
                    nxt_cur_src = oss_src_type'(req_src_ff);
                    nxt_req     = 1'b0;
                    nxt_sw    = SW_IDLE;
                    sts_set[IRQ_SWITCH] = 1'b1;
                end
            endcase
            // A failed clock falls back to fast RC and drops the request.
            if (fail_rise) begin
                nxt_fail_flag = 1'b1;
                nxt_cur_src   = SRC_FAST;
                nxt_req       = 1'b0;
                nxt_sw    = SW_IDLE;
                sts_set[IRQ_FAIL] = 1'b1;
            end
        end
        nxt_sts    = nxt_sts | sts_set;
        nxt_pll_en = nxt_cur_src == SRC_PRI_PLL ||
                     nxt_cur_src == SRC_FAST_PLL;
        nxt_osc2   = !crystal && osc2_pin_function_cfg;
        nxt_sec_on = nxt_lposc || nxt_cur_src == SRC_SEC;
        nxt_irq    = |(nxt_sts & nxt_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_src_ff         <= 3'h0;
            cur_source_ff      <= SRC_FAST;
            src_lock_ff        <= 1'b0;
            pin_config_lock_ff <= 1'b0;
            fail_flag_ff       <= 1'b0;
            lposc_ff           <= 1'b0;
            req_ff             <= 1'b0;
            sw_ff              <= SW_IDLE;
            boot_ff            <= 1'b0;
            fail_q_ff          <= 1'b0;
            pre_ff             <= PRE_RST;
            post_ff            <= POST_RST;
            div_ff             <= DIV_RST;
            apre_ff            <= APRE_RST;
            adiv_ff            <= ADIV_RST;
            sts_ff             <= IRQ_RST;
            mask_ff            <= IRQ_RST;
            pll_enable_ff      <= 1'b0;
            osc2_gpio_ff       <= 1'b0;
            sec_osc_on_ff      <= 1'b0;
            irq_ff             <= 1'b0;
        end else if (ce) begin
            req_src_ff         <= nxt_req_src;
            cur_source_ff      <= nxt_cur_src;
            src_lock_ff        <= nxt_src_lock;
            pin_config_lock_ff <= nxt_pin_lock;
            fail_flag_ff       <= nxt_fail_flag;
            lposc_ff           <= nxt_lposc;
            req_ff             <= nxt_req;
            sw_ff              <= nxt_sw;
            boot_ff            <= 1'b1;
            fail_q_ff          <= fail_s;
            pre_ff             <= nxt_pre;
            post_ff            <= nxt_post;
            div_ff             <= nxt_div;
            apre_ff            <= nxt_apre;
            adiv_ff            <= nxt_adiv;
            sts_ff             <= nxt_sts;
            mask_ff            <= nxt_mask;
            pll_enable_ff      <= nxt_pll_en;
            osc2_gpio_ff       <= nxt_osc2;
            sec_osc_on_ff      <= nxt_sec_on;
            irq_ff             <= nxt_irq;
        end
    end

    oss_pll_ratio u_ratio (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .pre     (pre_ff),
        .post    (post_ff),
        .div     (div_ff),
        .apre    (apre_ff),
        .adiv    (adiv_ff),
        .m_ff    (pll_m_ff),
        .n1_ff   (pll_n1_ff),
        .n2_ff   (pll_n2_ff),
        .am_ff   (aux_m_ff),
        .an1_ff  (aux_n1_ff)
    );

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_BOOT_SRC: assert property ($rose(boot_ff) |->
        cur_source_ff == $past(boot_src) && req_src_ff == $past(boot_src))
        else $error("Boot source not taken from configuration");
    AST_PLL_EN: assert property (ce && boot_ff |=> pll_enable_ff ==
        (cur_source_ff == SRC_PRI_PLL || cur_source_ff == SRC_FAST_PLL))
        else $error("PLL enable does not match current source");
    AST_OSC2: assert property (ce && !crystal |=>
        osc2_gpio_ff == $past(osc2_pin_function_cfg))
        else $error("Second pin function ignores its config bit");
    AST_CUR_SRC_RO: assert property (wr_ctrl && sw_ff == SW_IDLE
        && !fail_rise |=> $stable(cur_source_ff))
        else $error("Current source changed by a write");
    AST_REQ_SRC_WR: assert property (ce && boot_ff && wr_ctrl
        && !src_lock_ff |=> req_src_ff == $past(hwdata[10:8]))
        else $error("Requested source not written");
    AST_LOCKS: assert property (ce && boot_ff && wr_ctrl |=>
        src_lock_ff == $past(hwdata[7])
        && pin_config_lock_ff == $past(hwdata[6]))
        else $error("Lock bits not written");
    AST_FAIL_SET: assert property (ce && boot_ff && fail_rise |=>
        fail_flag_ff && cur_source_ff == SRC_FAST && !req_ff)
        else $error("Clock fail not flagged");
    AST_RSVD: assert property (ce && rd_ctrl |=> hrdata_ff[31:15] == 17'h0
        && !hrdata_ff[11] && !hrdata_ff[4] && !hrdata_ff[2])
        else $error("Unimplemented control bits read non-zero");
    AST_SWITCH: assert property (ce && sw_ff == SW_WAIT && src_ok
        && !fail_rise |=> cur_source_ff == $past(req_src_ff) && !req_ff
        && sts_ff[IRQ_SWITCH])
        else $error("Switch did not complete");
    AST_BUS_WAIT: assert property (take && ce |=> !hreadyout_ff ##1
        (hreadyout_ff || !$past(ce)))
        else $error("Bus wait state wrong");

    COV_SWITCH: cover property (sw_ff == SW_WAIT ##1 sw_ff == SW_IDLE);
    COV_FAIL: cover property (boot_ff && fail_rise);
    COV_IRQ: cover property ($rose(irq_ff));
endmodule
`default_nettype wire

// ==== test/oss_osc_model.sv ====
// Behavioural oscillators, PLL lock and fail monitor for the selector.
// Assumes the bench says which sources run, when the PLL may lock and
// when a clock failure is to be reported.
`timescale 1ns/1ps
`default_nettype none
module oss_osc_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [7:0] run_mask,
    input  wire logic       pll_want,
    input  wire logic       fail_req,
    output logic      [7:0] src_ready_ff,
    output logic            pll_lock_ff,
    output logic            clock_fail_ff
);
    logic [2:0] lock_cnt_ff;
    // Lock arrives eight cycles late so that a switch has to wait for it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_cnt_ff   <= 3'h0;
            src_ready_ff  <= 8'h00;
            pll_lock_ff   <= 1'b0;
            clock_fail_ff <= 1'b0;
        end else begin
            lock_cnt_ff   <= pll_want ? lock_cnt_ff + {2'h0, ~&lock_cnt_ff} : 3'h0;
            src_ready_ff  <= run_mask;
            pll_lock_ff   <= &lock_cnt_ff;
            clock_fail_ff <= fail_req;
        end
    end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the oscillator source selector.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import oss_pkg::*;
    typedef struct { logic [7:0] a; logic [31:0] d; logic [31:0] e; } oss_row_type;
    logic hclk, hresetn, hsel, hwrite, osc2_cfg, erased, pll_want, fail_req;
    logic [31:0] haddr, hwdata, hrdata, rdv, pv, av;
    logic [1:0] htrans, pmode;
    logic [2:0] strap;
    logic hready, hresp, pll_en, osc2_gpio, sec_on, pin_lock, irq, lock, cfail;
    logic [7:0] ready;
    oss_src_type cur;
    logic [9:0] m; logic [5:0] n1; logic [3:0] n2, an1; logic [6:0] am;
    int n_mismatch = 0, n_compared = 0;
    oss_row_type rows[6] = '{
        '{OFF_CTRL, 32'h0000_8856, 32'h0000_2042},
        '{OFF_PLL, 32'hFFFF_FFFF, 32'h01FF_00DF},
        '{OFF_AUX, 32'hFFFF_FFFF, 32'h0000_3F07},
        '{OFF_MASK, 32'h0000_0003, 32'h0000_0003},
        '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000},
        '{OFF_PLL, 32'h0000_0000, 32'h0000_0000}};
    oss_ctrl oss_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata_ff(hrdata),
        .hreadyout_ff(hready), .hresp_ff(hresp), .initial_source_config(strap),
        .primary_mode_config(pmode), .osc2_pin_function_cfg(osc2_cfg),
        .config_erased(erased), .src_ready_in(ready), .pll_lock_in(lock),
        .clock_fail_in(cfail), .cur_source_ff(cur), .pll_enable_ff(pll_en),
        .osc2_gpio_ff(osc2_gpio), .sec_osc_on_ff(sec_on),
        .pin_config_lock_ff(pin_lock), .irq_ff(irq), .pll_m_ff(m),
        .pll_n1_ff(n1), .pll_n2_ff(n2), .aux_m_ff(am), .aux_n1_ff(an1));
    oss_osc_model oss_osc_model_inst (.hclk(hclk), .hresetn(hresetn),
        .run_mask(8'hFF), .pll_want(pll_want), .fail_req(fail_req),
        .src_ready_ff(ready), .pll_lock_ff(lock), .clock_fail_ff(cfail));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Waits as long as the slave asks; only the watchdog ends a hang.
    task automatic wait_rdy();
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
    endtask
    // Each access is whole: address held until taken, data until ready.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
        wait_rdy();
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        wait_rdy();
        rdv = hrdata;
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask
    function automatic logic [31:0] ratio(input logic [31:0] p, input logic [31:0] q);
        return {1'b0, 10'(p[24:16] + 10'h2), 6'(p[4:0] + 6'h2),
            4'(({2'h0, p[7:6]} + 4'h1) << 1), 7'(q[13:8] + 7'h2), 4'(q[2:0] + 4'h2)};
    endfunction
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0;
        haddr = 32'h0; hwdata = 32'h0; strap = 3'h0; pmode = 2'h0;
        osc2_cfg = 1'b1; erased = 1'b0; pll_want = 1'b0; fail_req = 1'b0;
        pv = 32'h0; av = 32'h0;
        for (int i = 0; i < 8; i++) begin
            strap <= 3'(i); pmode <= 2'(i % 3);
            osc2_cfg <= (i != 0);
            do_reset();
            cmp({29'h0, cur}, 32'(i));
            cmp({31'h0, pll_en}, 32'(i == 1 || i == 3));
            cmp({31'h0, osc2_gpio}, 32'(i != 0 && i != 2));
        end
        erased <= 1'b1; strap <= SRC_PRI;
        do_reset();
        bus(OFF_CTRL, 1'b0, 32'h0);
        cmp(rdv, 32'h0000_7700);
        erased <= 1'b0; pmode <= PM_FAST_XTAL;
        do_reset();
        foreach (rows[i]) begin
            bus(rows[i].a, 1'b1, rows[i].d);
            bus(rows[i].a, 1'b0, 32'h0);
            cmp(rdv, rows[i].e);
            cmp({31'h0, hresp}, 32'h0);
            if (rows[i].a == OFF_PLL) pv = rows[i].d;
            if (rows[i].a == OFF_AUX) av = rows[i].d;
            cmp({1'b0, m, n1, n2, am, an1}, ratio(pv, av));
            if (i == 0) cmp({30'h0, pin_lock, sec_on}, 32'h3);
        end
        pll_want <= 1'b1;
        bus(OFF_CTRL, 1'b1, 32'h0000_0301);
        for (int n = 0; n < 60 && cur !== SRC_PRI_PLL; n++) @(posedge hclk);
        bus(OFF_CTRL, 1'b0, 32'h0);
        cmp(rdv, 32'h0000_3320);
        cmp({30'h0, pll_en, irq}, 32'h3);
        bus(OFF_STS, 1'b1, 32'h1);
        bus(OFF_STS, 1'b0, 32'h0);
        cmp({rdv[30:0], irq}, 32'h0);
        bus(OFF_CTRL, 1'b1, 32'h0000_0380);
        bus(OFF_CTRL, 1'b1, 32'h0000_0181);
        repeat (10) @(posedge hclk);
        bus(OFF_CTRL, 1'b0, 32'h0);
        cmp(rdv, 32'h0000_33A0);
        bus(OFF_CTRL, 1'b1, 32'h0000_0300);
        fail_req <= 1'b1;
        for (int n = 0; n < 20 && cur !== SRC_FAST; n++) @(posedge hclk);
        fail_req <= 1'b0;
        bus(OFF_CTRL, 1'b0, 32'h0);
        cmp(rdv & 32'h0000_7009, 32'h0000_0008);
        bus(OFF_STS, 1'b0, 32'h0);
        cmp({rdv[30:0], irq}, 32'h5);
        bus(OFF_CTRL, 1'b1, 32'h0000_0300);
        bus(OFF_STS, 1'b1, 32'h2);
        bus(OFF_CTRL, 1'b0, 32'h0);
        cmp({rdv[30:0] & 31'h8, irq}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
